/* hdl/page_xlate_pkg.sv */
// Purpose: Shared constants and types for the two level page translator
// Assumes: 32-bit linear and physical addresses, 4 Kbyte pages
// Notes: Register map is word aligned on an AHB-Lite slave
package page_xlate_pkg;
   localparam int ADDR_W = 32;
   localparam int PAGE_BYTES = 4096;
   localparam int OFF_W = $clog2(PAGE_BYTES);
   localparam int IDX_W = 10;
   localparam int BASE_W = ADDR_W - OFF_W;
   localparam int DIR_LO = 22;
   localparam int TBL_LO = 12;
   localparam int ENT_BYTES_W = 2;
   // Entry flag positions
   localparam int ENT_P = 0;
   localparam int ENT_US = 2;
   localparam int ENT_RW = 3;
   localparam int ENT_A = 5;
   localparam int ENT_D = 6;
   // Register map, byte offsets within the slave window
   localparam int REG_AW = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_DIR_BASE = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_FAULT = 8'h0C;
   localparam int CTRL_EN = 0;
   localparam int CTRL_USER = 1;
   localparam int STAT_PA = 0;
   localparam int STAT_PV = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [1:0] HRESP_OKAY = 2'h0;
   localparam int HTRANS_ACTIVE = 1;
   localparam int MAP_COUNT = 2;

   typedef struct packed {
      logic [BASE_W-1:0] tag;
      logic valid;
      logic wr_ok;
      logic [BASE_W-1:0] base;
   } xlate_entry_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic write;
      logic dst;
      logic [ADDR_W-1:0] wdata;
   } eng_req_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic write;
      logic [ADDR_W-1:0] wdata;
   } mem_req_type;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_CHECK = 4'h1,
      ST_DIR_RD = 4'h3,
      ST_DIR_WB = 4'h2,
      ST_TBL_RD = 4'h6,
      ST_TBL_WB = 4'h7,
      ST_DATA = 4'h5,
      ST_DONE = 4'h4,
      ST_FAULT = 4'hC
   } state_type;
endpackage

/* hdl/two_level_page_translator.sv */
// Purpose: Linear to physical translation for the drawing engine
// Assumes: Engine and memory ports run on clk_i; AHB-Lite register slave
// Notes: Two cached translations, page walk sets accessed and dirty flags
//
// What this block does
// - Translation off passes linear address straight through
// - Translation on converts every address before issue
// - Two table levels, 4 Kbyte pages
// - Split address into 10/10/12 bit fields
// - Directory entry upper 20 bits give table base
// - Table entry upper 20 bits give page base
// - Physical address is page base plus offset
// - Writes set dirty bit 6 in table entry
// - Any permitted access sets accessed bit 5 both levels
// - Supervisor accesses skip all permission checks
// - User access denied when user-permit bit clear
// - User write needs write-permit, reads need user-permit
// - Entry usable only with present bit 0 set
// - Two cached translations, source side and destination
// - Flush both on base write or suspend
// - Absent entry raises flag, clearing it retries
// - User violation raises flag and terminates access
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module two_level_page_translator (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic eng_valid_i,
   input wire page_xlate_pkg::eng_req_type eng_req_i,
   input wire logic suspend_i,
   output logic eng_done_o,
   output logic eng_abort_o,
   output logic [31:0] eng_rdata_o,
   output logic mem_valid_o,
   output page_xlate_pkg::mem_req_type mem_req_o,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_rdata_i,
   output logic page_absent_o,
   output logic prot_viol_o
);
   import page_xlate_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic [ADDR_W-1:0] ent_addr(
      input logic [BASE_W-1:0] base,
      input logic [IDX_W-1:0] idx
   );
      ent_addr = {base, idx, {ENT_BYTES_W{1'b0}}};
   endfunction

   function automatic logic perm_ok(
      input logic [ADDR_W-1:0] ent,
      input logic wr
   );
      perm_ok = ent[ENT_US] & (~wr | ent[ENT_RW]);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register slave

   logic [1:0] ctrl_q;
   logic [BASE_W-1:0] dir_base_q;
   logic pa_q, pa_d;
   logic pv_q, pv_d;
   logic [ADDR_W-1:0] fault_q;
   logic wr_pend_q;
   logic [REG_AW-1:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic hresp_q;
   logic set_pa, set_pv;

   wire addr_phase = hsel_i & htrans_i[HTRANS_ACTIVE] & hready_i;
   wire [REG_AW-1:0] rd_addr = haddr_i[REG_AW-1:0];
   wire ctrl_wr = wr_pend_q & (wr_addr_q == REG_CTRL);
   wire base_wr = wr_pend_q & (wr_addr_q == REG_DIR_BASE);
   wire stat_wr = wr_pend_q & (wr_addr_q == REG_STATUS);
   wire xlate_en = ctrl_q[CTRL_EN];
   wire user_mode = ctrl_q[CTRL_USER];
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = '0;
      case (rd_addr)
         REG_CTRL: rd_mux = {30'h0, ctrl_q};
         REG_DIR_BASE: rd_mux = {dir_base_q, {OFF_W{1'b0}}};
         REG_STATUS: rd_mux = {30'h0, pv_q, pa_q};
         REG_FAULT: rd_mux = fault_q;
         default: rd_mux = '0;
      endcase
   end

   // Hardware set wins over a same-cycle software clear
   assign pa_d = set_pa | (pa_q & ~(stat_wr & hwdata_i[STAT_PA]));
   assign pv_d = set_pv | (pv_q & ~(stat_wr & hwdata_i[STAT_PV]));

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
         hrdata_q <= '0;
         hreadyout_q <= 1'b0;
         hresp_q <= 1'b0;
      end else begin
         wr_pend_q <= addr_phase & hwrite_i;
         wr_addr_q <= rd_addr;
         hrdata_q <= (addr_phase & ~hwrite_i) ? rd_mux : '0;
         hreadyout_q <= 1'b1;
         hresp_q <= HRESP_OKAY[0];
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_q <= CTRL_RESET;
         dir_base_q <= '0;
         pa_q <= 1'b0;
         pv_q <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            ctrl_q <= hwdata_i[1:0];
         end
         if (base_wr) begin
            dir_base_q <= hwdata_i[ADDR_W-1:OFF_W];
         end
         pa_q <= pa_d;
         pv_q <= pv_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Cached translations

   xlate_entry_type xlate_pair_q [MAP_COUNT];
   logic fill;
   eng_req_type lin_q, lin_d;
   logic [ADDR_W-1:0] tbl_ent_q, tbl_ent_d;
   // Mode change also flushes so a stale user check cannot be reused
   wire flush = base_wr | suspend_i | ctrl_wr;

   genvar gi;
   generate
      for (gi = 0; gi < MAP_COUNT; gi++) begin : g_entry
         always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               xlate_pair_q[gi] <= '0;
            end else if (flush) begin
               xlate_pair_q[gi].valid <= 1'b0;
            end else if (fill & (lin_q.dst == 1'(gi))) begin
               xlate_pair_q[gi].tag <= lin_q.addr[ADDR_W-1:OFF_W];
               xlate_pair_q[gi].valid <= 1'b1;
               xlate_pair_q[gi].wr_ok <= lin_q.write;
               xlate_pair_q[gi].base <= tbl_ent_d[ADDR_W-1:OFF_W];
            end
         end
      end
   endgenerate

   // Destination map uses entry 1, source/pattern/mask entry 0
   wire xlate_entry_type cur = xlate_pair_q[lin_q.dst];
   wire hit = cur.valid & (cur.tag == lin_q.addr[ADDR_W-1:OFF_W])
      & (~lin_q.write | cur.wr_ok);

   ////////////////////////////////////////////////////////////////////////
   // Page walk

   state_type state_q, state_d;
   logic [ADDR_W-1:0] dir_ent_q, dir_ent_d;
   logic mem_valid_q, mem_valid_d;
   mem_req_type mem_q, mem_d;
   logic done_q, done_d, abort_q, abort_d;
   logic [31:0] rdata_q, rdata_d;

   wire [IDX_W-1:0] dir_idx = lin_q.addr[ADDR_W-1:DIR_LO];
   wire [IDX_W-1:0] tbl_idx = lin_q.addr[DIR_LO-1:TBL_LO];
   wire [OFF_W-1:0] offset = lin_q.addr[OFF_W-1:0];
   wire ack = mem_valid_q & mem_ack_i;
   wire [ADDR_W-1:0] dir_acc = mem_rdata_i | (ADDR_W'(1) << ENT_A);
   wire [ADDR_W-1:0] tbl_acc = mem_rdata_i | (ADDR_W'(1) << ENT_A)
      | (ADDR_W'(lin_q.write) << ENT_D);
   wire [ADDR_W-1:0] dir_addr = ent_addr(dir_base_q, dir_idx);
   wire [ADDR_W-1:0] tbl_addr =
      ent_addr(dir_ent_q[ADDR_W-1:OFF_W], tbl_idx);
   wire [ADDR_W-1:0] page_addr =
      {tbl_ent_d[ADDR_W-1:OFF_W], offset};
   wire [ADDR_W-1:0] hit_addr = {cur.base, offset};

   always_comb begin
      state_d = state_q;
      lin_d = lin_q;
      dir_ent_d = dir_ent_q;
      tbl_ent_d = tbl_ent_q;
      mem_valid_d = mem_valid_q & ~mem_ack_i;
      mem_d = mem_q;
      done_d = 1'b0;
      abort_d = 1'b0;
      rdata_d = rdata_q;
      fill = 1'b0;
      set_pa = 1'b0;
      set_pv = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (eng_valid_i) begin
               lin_d = eng_req_i;
               state_d = ST_CHECK;
            end
         end
         ST_CHECK: begin
            mem_valid_d = 1'b1;
            if (!xlate_en) begin
               mem_d = '{lin_q.addr, lin_q.write, lin_q.wdata};
               state_d = ST_DATA;
            end else if (hit) begin
               mem_d = '{hit_addr, lin_q.write, lin_q.wdata};
               state_d = ST_DATA;
            end else begin
               mem_d = '{dir_addr, 1'b0, '0};
               state_d = ST_DIR_RD;
            end
         end
         ST_DIR_RD: begin
            if (ack) begin
               dir_ent_d = dir_acc;
               if (!mem_rdata_i[ENT_P]) begin
                  set_pa = 1'b1;
                  state_d = ST_FAULT;
               end else if (user_mode & ~perm_ok(mem_rdata_i, lin_q.write))
               begin
                  set_pv = 1'b1;
                  done_d = 1'b1;
                  abort_d = 1'b1;
                  state_d = ST_DONE;
               end else if (!mem_rdata_i[ENT_A]) begin
                  mem_valid_d = 1'b1;
                  mem_d = '{mem_q.addr, 1'b1, dir_acc};
                  state_d = ST_DIR_WB;
               end else begin
                  mem_valid_d = 1'b1;
                  mem_d = '{ent_addr(mem_rdata_i[ADDR_W-1:OFF_W], tbl_idx),
                     1'b0, '0};
                  state_d = ST_TBL_RD;
               end
            end
         end
         ST_DIR_WB: begin
            if (ack) begin
               mem_valid_d = 1'b1;
               mem_d = '{tbl_addr, 1'b0, '0};
               state_d = ST_TBL_RD;
            end
         end
         ST_TBL_RD: begin
            if (ack) begin
               tbl_ent_d = tbl_acc;
               if (!mem_rdata_i[ENT_P]) begin
                  set_pa = 1'b1;
                  state_d = ST_FAULT;
               end else if (user_mode & ~perm_ok(mem_rdata_i, lin_q.write))
               begin
                  set_pv = 1'b1;
                  done_d = 1'b1;
                  abort_d = 1'b1;
                  state_d = ST_DONE;
               end else if (tbl_acc != mem_rdata_i) begin
                  mem_valid_d = 1'b1;
                  mem_d = '{mem_q.addr, 1'b1, tbl_acc};
                  state_d = ST_TBL_WB;
               end else begin
                  fill = 1'b1;
                  mem_valid_d = 1'b1;
                  mem_d = '{page_addr, lin_q.write, lin_q.wdata};
                  state_d = ST_DATA;
               end
            end
         end
         ST_TBL_WB: begin
            if (ack) begin
               fill = 1'b1;
               mem_valid_d = 1'b1;
               mem_d = '{page_addr, lin_q.write, lin_q.wdata};
               state_d = ST_DATA;
            end
         end
         ST_DATA: begin
            if (ack) begin
               rdata_d = mem_rdata_i;
               done_d = 1'b1;
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            state_d = ST_IDLE;
         end
         ST_FAULT: begin
            // Walk restarts once software has cleared the flag
            if (!pa_q) begin
               state_d = ST_CHECK;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= ST_IDLE;
         lin_q <= '0;
         dir_ent_q <= '0;
         tbl_ent_q <= '0;
         mem_valid_q <= 1'b0;
         mem_q <= '0;
         done_q <= 1'b0;
         abort_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         state_q <= state_d;
         lin_q <= lin_d;
         dir_ent_q <= dir_ent_d;
         tbl_ent_q <= tbl_ent_d;
         mem_valid_q <= mem_valid_d;
         mem_q <= mem_d;
         done_q <= done_d;
         abort_q <= abort_d;
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fault_q <= '0;
      end else if (set_pa | set_pv) begin
         fault_q <= lin_q.addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign hrdata_o = hrdata_q;
   assign hreadyout_o = hreadyout_q;
   assign hresp_o = hresp_q;
   assign eng_done_o = done_q;
   assign eng_abort_o = abort_q;
   assign eng_rdata_o = rdata_q;
   assign mem_valid_o = mem_valid_q;
   assign mem_req_o = mem_q;
   assign page_absent_o = pa_q;
   assign prot_viol_o = pv_q;
endmodule
`default_nettype wire

/* verif/page_xlate_props.sv */
// Purpose: Port checker for the page translator
// Assumes: One clock, async high reset
// Notes: Bound to the translator module by the bind below
`timescale 1ns/1ps
`default_nettype none
module page_xlate_props
   import page_xlate_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic eng_done_o,
   input wire logic eng_abort_o,
   input wire logic mem_valid_o,
   input wire logic mem_ack_i,
   input wire logic page_absent_o,
   input wire logic prot_viol_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   wire logic st_wr = hsel_i & htrans_i[1] & hready_i & hwrite_i
      & (haddr_i[7:0] == REG_STATUS);
   ////////////////////////////////////////////////////////////////////
   chk_abort_done: assert property (eng_abort_o |-> eng_done_o)
      else $error("abort seen without done");
   chk_viol_flag: assert property
      (eng_abort_o |-> ##[0:1] prot_viol_o)
      else $error("abort without violation flag");
   chk_done_pulse: assert property (eng_done_o |=> !eng_done_o)
      else $error("done longer than one cycle");
   chk_data_acked: assert property
      (eng_done_o && !eng_abort_o |-> $past(mem_ack_i))
      else $error("done without memory answer");
   chk_absent_stall: assert property (page_absent_o |-> !eng_done_o)
      else $error("access finished while page absent");
   chk_absent_quiet: assert property
      (page_absent_o && $past(page_absent_o) |-> !mem_valid_o)
      else $error("memory request during absent stall");
   chk_viol_clear: assert property
      ($fell(prot_viol_o) |-> $past(st_wr, 2))
      else $error("violation flag dropped unasked");
   chk_absent_clear: assert property
      ($fell(page_absent_o) |-> $past(st_wr, 2))
      else $error("absent flag dropped unasked");
   cover property (eng_abort_o);
   cover property (page_absent_o ##[1:60] !page_absent_o);
   cover property (eng_done_o && !eng_abort_o);
endmodule
bind two_level_page_translator page_xlate_props i_chk (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
   .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
   .hready_i(hready_i), .eng_done_o(eng_done_o),
   .eng_abort_o(eng_abort_o), .mem_valid_o(mem_valid_o),
   .mem_ack_i(mem_ack_i), .page_absent_o(page_absent_o),
   .prot_viol_o(prot_viol_o));
`default_nettype wire

/* verif/mem_model.sv */
// Purpose: Host and video memory behind the translator
// Assumes: Word keyed store, untouched words read as inverted address
// Notes: Latency from lat_i; idle data toggles so stale data never matches
`timescale 1ns/1ps
`default_nettype none
module mem_model
   import page_xlate_pkg::*;
(
   input wire logic clk_i,
   input wire logic [1:0] lat_i,
   input wire logic valid_i,
   input wire page_xlate_pkg::mem_req_type req_i,
   output logic ack_o,
   output logic [31:0] rdata_o
);
   logic [31:0] mem [logic [31:0]];
   logic [1:0] wait_q = 2'h0;
   wire logic [31:0] wa = {req_i.addr[31:2], 2'b00};
   initial ack_o = 1'b0;
   initial rdata_o = 32'h0;
   function automatic logic [31:0] peek(input logic [31:0] a);
      return mem.exists(a) ? mem[a] : ~a;
   endfunction
   always @(posedge clk_i) begin
      if (valid_i === 1'b1 && !ack_o && wait_q >= lat_i) begin
         ack_o <= 1'b1;
         wait_q <= 2'h0;
         if (req_i.write)
            mem[wa] = req_i.wdata;
         rdata_o <= req_i.write ? ~rdata_o : peek(wa);
      end else begin
         ack_o <= 1'b0;
         rdata_o <= ~rdata_o;
         if (valid_i === 1'b1 && !ack_o)
            wait_q <= wait_q + 2'h1;
      end
   end
endmodule
`default_nettype wire

/* verif/tb.sv */
// Purpose: Self-checking bench for the page translator
// Assumes: Memory model answers with random latency
// Notes: Expected engine results go through a queue to a watcher
`timescale 1ns/1ps
`default_nettype none
module tb;
   import page_xlate_pkg::*;
   localparam logic [31:0] DIR = 32'h0001_0000;
   localparam logic [31:0] TBL = 32'h0002_0000;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic hsel_i = 1'b0;
   logic hwrite_i = 1'b0;
   logic eng_valid_i = 1'b0;
   logic suspend_i = 1'b0;
   logic [1:0] htrans_i = 2'h0;
   logic [1:0] lat = 2'h0;
   logic [31:0] haddr_i = 32'h0;
   logic [31:0] hwdata_i = 32'h0;
   eng_req_type eng_req_i = '0;
   logic hreadyout_o, hresp_o, eng_done_o, eng_abort_o;
   logic mem_valid_o, mem_ack_i, page_absent_o, prot_viol_o;
   logic [31:0] hrdata_o, eng_rdata_o, mem_rdata_i;
   mem_req_type mem_req_o;
   logic [33:0] exp_q [$];
   logic [33:0] we;
   int n_mismatch = 0;
   int samples_checked = 0;
   always #10 clk_i = ~clk_i;
   two_level_page_translator i_dut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
      .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
      .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .eng_valid_i(eng_valid_i), .eng_req_i(eng_req_i),
      .suspend_i(suspend_i), .eng_done_o(eng_done_o),
      .eng_abort_o(eng_abort_o), .eng_rdata_o(eng_rdata_o),
      .mem_valid_o(mem_valid_o), .mem_req_o(mem_req_o),
      .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
      .page_absent_o(page_absent_o), .prot_viol_o(prot_viol_o));
   mem_model i_mem (.clk_i(clk_i), .lat_i(lat), .valid_i(mem_valid_o),
      .req_i(mem_req_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic edge_rdy();
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1)
         @(posedge clk_i);
   endtask
   task automatic ahb(input logic w, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] rd);
      hsel_i <= 1'b1;
      htrans_i <= 2'b10;
      haddr_i <= {24'h0, a};
      hwrite_i <= w;
      edge_rdy();
      hsel_i <= 1'b0;
      htrans_i <= 2'b00;
      hwdata_i <= wd;
      edge_rdy();
      rd = hrdata_o;
      check({31'h0, hresp_o}, 32'h0);
   endtask
   task automatic issue(input logic [31:0] a, input logic w,
         input logic [31:0] wd, input logic d, input logic [33:0] e);
      exp_q.push_back(e);
      lat <= 2'($urandom_range(3, 0));
      eng_valid_i <= 1'b1;
      eng_req_i <= '{addr: a, write: w, dst: d, wdata: wd};
   endtask
   task automatic finish();
      int n;
      n = 0;
      @(posedge clk_i);
      while (eng_done_o !== 1'b1 && n < 500) begin
         @(posedge clk_i);
         n++;
      end
      eng_valid_i <= 1'b0;
      if (n == 500)
         n_mismatch++;
      // One idle edge so the next request never rewrites valid at once
      @(posedge clk_i);
   endtask
   task automatic xfer(input logic [31:0] a, input logic w,
         input logic [31:0] wd, input logic d, input logic [33:0] e);
      issue(a, w, wd, d, e);
      finish();
   endtask
   function automatic logic [31:0] de(input logic [31:0] l);
      return DIR + {20'h0, l[31:22], 2'b00};
   endfunction
   function automatic logic [31:0] te(input logic [31:0] l);
      return TBL + {20'h0, l[21:12], 2'b00};
   endfunction
   task automatic map(input logic [31:0] l, input logic [3:0] df,
         input logic [3:0] tf, input logic [31:0] pg);
      i_mem.mem[de(l)] = {TBL[31:12], 8'h00, df};
      i_mem.mem[te(l)] = {pg[31:12], 8'h00, tf};
   endtask
   task automatic pick(output logic [31:0] l, pg, ph);
      l = $urandom() & 32'hFFFF_FFFC;
      pg = {4'h8, 16'($urandom()), 12'h000};
      ph = {pg[31:12], l[11:0]};
   endtask
   // Watcher: every done takes the oldest note
   always @(posedge clk_i) begin
      if (eng_done_o === 1'b1) begin
         check({31'h0, exp_q.size() > 0}, 32'h1);
         if (exp_q.size() > 0) begin
            we = exp_q.pop_front();
            check({31'h0, eng_abort_o}, {31'h0, we[32]});
            if (we[33])
               check(eng_rdata_o, we[31:0]);
         end
      end
   end
   initial begin
      #400000;
      n_mismatch++;
      give_verdict();
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] l, pg, ph, rd, wd;
      logic [3:0] tf [5];
      logic d, ok;
      tf = '{4'h1, 4'h9, 4'h5, 4'hD, 4'hD};
      void'($urandom(32'hEC2EE3EC));
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      // Reset values, unmapped hole reads zero
      for (int i = 0; i < 5; i++) begin
         ahb(1'b0, 8'(i * 4) | ((i == 4) ? 8'h40 : 8'h00), 32'h0, rd);
         check(rd, 32'h0);
      end
      // Translation off: straight through
      for (int i = 0; i < 3; i++) begin
         l = $urandom() & 32'hFFFF_FFFC;
         wd = $urandom();
         xfer(l, 1'b0, 32'h0, i[0], {2'b10, i_mem.peek(l)});
         xfer(l, 1'b1, wd, i[0], 34'h0);
         check(i_mem.peek(l), wd);
      end
      // Supervisor walks ignore permission bits
      ahb(1'b1, REG_DIR_BASE, DIR, rd);
      ahb(1'b1, REG_CTRL, 32'h1, rd);
      for (int i = 0; i < 4; i++) begin
         pick(l, pg, ph);
         map(l, 4'h1, 4'h1, pg);
         d = i[0];
         xfer(l, 1'b0, 32'h0, d, {2'b10, i_mem.peek(ph)});
         rd = i_mem.mem[de(l)] & i_mem.mem[te(l)];
         check(rd & 32'h20, 32'h20);
         wd = $urandom();
         xfer(l, 1'b1, wd, d, 34'h0);
         check(i_mem.peek(ph), wd);
         check(i_mem.mem[te(l)] & 32'h60, 32'h60);
      end
      // Stale hit until suspend, then base write flushes again
      map(l, 4'h1, 4'h1, 32'h9000_0000);
      xfer(l, 1'b0, 32'h0, d, {2'b10, wd});
      suspend_i <= 1'b1;
      @(posedge clk_i);
      suspend_i <= 1'b0;
      xfer(l, 1'b0, 32'h0, d, {2'b10, ~{20'h90000, l[11:0]}});
      map(l, 4'h1, 4'h1, pg);
      ahb(1'b1, REG_DIR_BASE, DIR, rd);
      xfer(l, 1'b0, 32'h0, d, {2'b10, wd});
      // User mode: every permission pair, then a denied directory
      ahb(1'b1, REG_CTRL, 32'h3, rd);
      for (int i = 0; i < 5; i++) begin
         for (int w = 0; w < 2; w++) begin
            ahb(1'b1, REG_DIR_BASE, DIR, rd);
            pick(l, pg, ph);
            map(l, (i == 4) ? 4'h1 : 4'hD, tf[i], pg);
            ok = tf[i][2] & (w == 0 | tf[i][3]) & (i < 4);
            xfer(l, w[0], 32'h0, 1'b0,
               {!w[0] & ok, !ok, i_mem.peek(ph)});
            if (!ok) begin
               ahb(1'b0, REG_STATUS, 32'h0, rd);
               check(rd, 32'h2);
               ahb(1'b1, REG_STATUS, 32'h2, rd);
            end
            if (i == 4)
               check(i_mem.mem[te(l)] & 32'h20, 32'h0);
         end
      end
      // Absent directory entry: stall, repair, clear, retry
      ahb(1'b1, REG_CTRL, 32'h1, rd);
      ahb(1'b1, REG_DIR_BASE, DIR, rd);
      pick(l, pg, ph);
      map(l, 4'h0, 4'h1, pg);
      issue(l, 1'b0, 32'h0, 1'b1, {2'b10, i_mem.peek(ph)});
      for (int n = 0; n < 200 && page_absent_o !== 1'b1; n++)
         @(posedge clk_i);
      ahb(1'b0, REG_STATUS, 32'h0, rd);
      check(rd & 32'h1, 32'h1);
      ahb(1'b0, REG_FAULT, 32'h0, rd);
      check(rd, l);
      map(l, 4'h1, 4'h1, pg);
      ahb(1'b1, REG_STATUS, 32'h1, rd);
      finish();
      repeat (4) @(posedge clk_i);
      check(32'(exp_q.size()), 32'h0);
      give_verdict();
   end
endmodule
`default_nettype wire
